/* core/usbbdt_params.svh */
`ifndef USBBDT_PARAMS_SVH
`define USBBDT_PARAMS_SVH

// ==========================================================
// Local RAM layout
// ==========================================================
`define USBBDT_RAM_BYTES 256
`define USBBDT_TABLE_LAST 8'h1D
`define USBBDT_RSVD_FIRST 8'h1E
`define USBBDT_RSVD_LAST 8'h1F
`define USBBDT_BUF_FIRST 8'h20
`define USBBDT_BUF_LAST 8'hFF
`define USBBDT_DESC_BYTES 8'h03
`define USBBDT_MAX_PKT 7'h40

// ==========================================================
// Descriptor byte offsets and control byte fields
// ==========================================================
`define USBBDT_OFS_CTRL 8'h00
`define USBBDT_OFS_COUNT 8'h01
`define USBBDT_OFS_PTR 8'h02
`define USBBDT_BIT_OWN 7
`define USBBDT_BIT_TOGGLE 6
`define USBBDT_BIT_SYNC 3
`define USBBDT_BIT_STALL 2
`define USBBDT_PID_LSB 2

// ==========================================================
// Token PID codes
// ==========================================================
`define USBBDT_PID_OUT 4'h1
`define USBBDT_PID_IN 4'h9
`define USBBDT_PID_SETUP 4'hD

// ==========================================================
// Extra registers above the RAM window
// ==========================================================
`define USBBDT_ADDR_STATUS 9'h100
`define USBBDT_ADDR_FLAG 9'h101

`endif

/* core/usbbdt_pkg.sv */
package usbbdt_pkg;

	// Descriptor engine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_CTRL,
		ST_RD_COUNT,
		ST_RD_PTR,
		ST_XFER,
		ST_WB_COUNT,
		ST_WB_CTRL
	} usbbdt_state_t;

	// Answer for the serial engine after the lookup
	typedef enum logic [1:0] {
		RESP_ACK,
		RESP_NAK,
		RESP_STALL
	} usbbdt_resp_t;

	// Token handed in by the serial engine
	typedef struct packed {
		logic [2:0] ep;
		logic [3:0] pid;
		logic odd;
	} usbbdt_token_t;

	// Descriptor summary handed back to the serial engine
	typedef struct packed {
		usbbdt_resp_t resp;
		logic toggle;
		logic sync;
		logic [7:0] count;
	} usbbdt_desc_t;

	// Whole state of the table block
	typedef struct packed {
		usbbdt_state_t st;
		usbbdt_token_t tok;
		logic [7:0] base;
		logic [7:0] ctrl;
		logic [7:0] ptr;
		logic [6:0] cnt;
		logic rxPend;
		logic [7:0] rxByte;
		logic txPend;
		logic [5:0] txOfs;
		logic donePend;
		logic doneToggle;
		logic [7:0] rdData;
		logic descValid;
		usbbdt_desc_t desc;
		logic txValid;
		logic [7:0] txData;
		logic rxReady;
		logic tokDone;
		logic [7:0] status;
		logic doneFlag;
	} usbbdt_regs_t;

endpackage

/* core/usbbdt_table.sv */
// The plain strobed port was decided locally.
`timescale 1ns/100ps
// Functional notes
// - Bytes 0x00-0x1D hold the fixed descriptor table
// - Every descriptor is three consecutive bytes
// - Order EP0 IN/OUT, EP1-4, EP5/EP6 even/odd
// - 0x1E-0x1F reserved, 0x20-0xFF buffer space
// - Token on enabled endpoint reads descriptor ownership
// - Control byte, count byte, pointer byte layout
// - Owner clear means other fields ignored
// - Completion clears ownership, returning descriptor
// - Processor accesses never blocked, even when owned
// - Toggle bit selects DATA0/DATA1, kept unchanged
// - Sync enable turns toggle checking on
// - Stall bit answers STALL, descriptor untouched
// - Receive completion rewrites seven-bit byte count
// - Packets limited to 64 bytes
// - Pointer gives address bits 9-2, low bits zero
// - Engine never rewrites the buffer pointer
// - Completion writes token PID into bits 5-2
// - Descriptor location from endpoint, direction, parity
// - Write-back updates status and token-done flag
`include "usbbdt_params.svh"

module usbbdt_table #(
	parameter int RAM_BYTES = `USBBDT_RAM_BYTES, // Local RAM size
	parameter logic [6:0] MAX_PKT = `USBBDT_MAX_PKT // Packet ceiling
) (
	input wire logic clk, // 40 MHz clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic [8:0] cpuAddr, // Processor byte address
	input wire logic [7:0] cpuWdata, // Processor write data
	input wire logic cpuWr, // Processor write strobe
	input wire logic cpuRd, // Processor read strobe
	output logic [7:0] cpuRdata, // Read data, cycle after strobe
	input wire logic [6:0] epEnable, // Endpoint enables, one per endpoint
	input wire logic tokValid, // Token arrived, one-cycle pulse
	input wire usbbdt_pkg::usbbdt_token_t tokIn, // Token fields
	output logic descValid, // Lookup answer, one-cycle pulse
	output usbbdt_pkg::usbbdt_desc_t descOut, // Lookup answer fields
	input wire logic rxValid, // Received data byte offered
	input wire logic [7:0] rxData, // Received data byte
	output logic rxReady, // Ready to take a received byte
	input wire logic txReq, // Request for next byte to send
	output logic txValid, // Byte to send ready, one-cycle pulse
	output logic [7:0] txData, // Byte to send
	input wire logic xferDone, // Packet finished, one-cycle pulse
	input wire logic xferToggle, // Toggle of the packet seen on the wire
	output logic tokDone, // Write-back finished, one-cycle pulse
	output logic tokenDoneFlag // Sticky token-done flag
);
	import usbbdt_pkg::*;

	// ==========================================================
	// Helper functions
	// ==========================================================

	// Descriptor slot from endpoint, direction and buffer parity
	function automatic logic [7:0] descBase(input usbbdt_token_t t);
		logic [7:0] idx;
		idx = 8'h00;
		unique case (t.ep)
			3'h0: idx = (t.pid == `USBBDT_PID_IN) ? 8'h00 : 8'h01;
			3'h5: idx = t.odd ? 8'h07 : 8'h06;
			3'h6: idx = t.odd ? 8'h09 : 8'h08;
			default: idx = 8'({5'h00, t.ep}) + 8'h01;
		endcase
		return 8'(idx * `USBBDT_DESC_BYTES);
	endfunction

	// Local RAM byte address from pointer field and offset
	function automatic logic [7:0] bufAddr(input logic [7:0] p,
		input logic [6:0] o);
		logic [9:0] a;
		a = {p, 2'b00} + 10'({3'h0, o});
		return a[7:0];
	endfunction

	// Tokens that fill the buffer rather than drain it
	function automatic logic isRx(input logic [3:0] pid);
		return pid != `USBBDT_PID_IN;
	endfunction

	// ==========================================================
	// Storage
	// ==========================================================
	logic [7:0] ram [RAM_BYTES]; // Shared table and buffer RAM
	usbbdt_regs_t r_q; // Registered state
	usbbdt_regs_t r_d; // Next state
	logic memWe; // RAM write enable this cycle
	logic [7:0] memAddr; // RAM write address
	logic [7:0] memWd; // RAM write data
	logic cpuBusy; // Processor owns the RAM port this cycle

	// Processor strobe takes the port; the engine just waits a cycle.
	// Waiting is cheap because the engine holds its request in state.
	assign cpuBusy = cpuWr | cpuRd;

	// ==========================================================
	// Next-state logic
	// ==========================================================
	always_comb begin
		r_d = r_q;
		memWe = 1'b0;
		memAddr = 8'h00;
		memWd = 8'h00;
		r_d.descValid = 1'b0;
		r_d.txValid = 1'b0;
		r_d.tokDone = 1'b0;

		// Processor side: no ownership check at all, owned or not
		if (cpuWr && !cpuAddr[8]) begin
			memWe = 1'b1;
			memAddr = cpuAddr[7:0];
			memWd = cpuWdata;
		end
		if (cpuRd) begin
			if (!cpuAddr[8]) begin
				r_d.rdData = ram[cpuAddr[7:0]];
			end else if (cpuAddr == `USBBDT_ADDR_STATUS) begin
				r_d.rdData = r_q.status;
			end else if (cpuAddr == `USBBDT_ADDR_FLAG) begin
				r_d.rdData = {7'h00, r_q.doneFlag};
			end else begin
				r_d.rdData = 8'h00; // Unmapped reads as zero
			end
		end
		// Write one to clear; a new completion below wins over it
		if (cpuWr && cpuAddr == `USBBDT_ADDR_FLAG && cpuWdata[0]) begin
			r_d.doneFlag = 1'b0;
		end

		// Completion pulses are caught at once and served in order
		if (xferDone && r_q.st == ST_XFER) begin
			r_d.donePend = 1'b1;
			r_d.doneToggle = xferToggle;
		end
		// Received byte captured into a one-byte holding slot
		if (rxValid && r_q.rxReady) begin
			r_d.rxPend = 1'b1;
			r_d.rxByte = rxData;
		end
		if (txReq && r_q.st == ST_XFER) begin
			r_d.txPend = 1'b1;
		end

		// Engine side; RAM accesses only in slots the processor leaves free
		unique case (r_q.st)
			ST_IDLE: begin
				// Tokens for disabled endpoints are dropped silently
				if (tokValid && epEnable[tokIn.ep]) begin
					r_d.tok = tokIn;
					r_d.base = descBase(tokIn);
					r_d.cnt = 7'h00;
					r_d.txOfs = 6'h00;
					r_d.donePend = 1'b0;
					r_d.rxPend = 1'b0;
					r_d.txPend = 1'b0;
					r_d.st = ST_RD_CTRL;
				end
			end
			ST_RD_CTRL: begin
				if (!cpuBusy) begin
					r_d.ctrl = ram[r_q.base + `USBBDT_OFS_CTRL];
					if (!r_d.ctrl[`USBBDT_BIT_OWN]) begin
						// Not ours: nothing else in it is looked at
						r_d.desc = '{RESP_NAK, 1'b0, 1'b0, 8'h00};
						r_d.descValid = 1'b1;
						r_d.st = ST_IDLE;
					end else if (r_d.ctrl[`USBBDT_BIT_STALL]) begin
						// Stall leaves the descriptor exactly as found
						r_d.desc = '{RESP_STALL, 1'b0, 1'b0, 8'h00};
						r_d.descValid = 1'b1;
						r_d.st = ST_IDLE;
					end else begin
						r_d.st = ST_RD_COUNT;
					end
				end
			end
			ST_RD_COUNT: begin
				if (!cpuBusy) begin
					r_d.desc.count = ram[r_q.base + `USBBDT_OFS_COUNT];
					r_d.st = ST_RD_PTR;
				end
			end
			ST_RD_PTR: begin
				if (!cpuBusy) begin
					r_d.ptr = ram[r_q.base + `USBBDT_OFS_PTR];
					r_d.desc.resp = RESP_ACK;
					r_d.desc.toggle = r_q.ctrl[`USBBDT_BIT_TOGGLE];
					r_d.desc.sync = r_q.ctrl[`USBBDT_BIT_SYNC];
					r_d.descValid = 1'b1;
					r_d.rxReady = isRx(r_q.tok.pid);
					r_d.st = ST_XFER;
				end
			end
			ST_XFER: begin
				if (r_q.rxPend && !cpuBusy) begin
					// Bytes past the ceiling are dropped, neither stored nor counted
					if (r_q.cnt < MAX_PKT) begin
						memWe = 1'b1;
						memAddr = bufAddr(r_q.ptr, r_q.cnt);
						memWd = r_q.rxByte;
						r_d.cnt = 7'(r_q.cnt + 7'h01);
					end
					r_d.rxPend = 1'b0;
				end else if (r_q.txPend && !cpuBusy) begin
					r_d.txData = ram[bufAddr(r_q.ptr, 7'({1'b0, r_q.txOfs}))];
					r_d.txValid = 1'b1;
					r_d.txOfs = 6'(r_q.txOfs + 6'h01);
					r_d.txPend = 1'b0;
				end else if (r_q.donePend && !r_q.rxPend) begin
					r_d.donePend = 1'b0;
					r_d.rxReady = 1'b0;
					// Toggle mismatch: packet discarded, descriptor kept
					if (r_q.desc.sync &&
						r_q.doneToggle != r_q.desc.toggle) begin
						r_d.st = ST_IDLE;
					end else begin
						r_d.st = ST_WB_COUNT;
					end
				end
				// Holding slot busy means no new byte this cycle
				if (r_d.rxPend || r_d.st != ST_XFER) begin
					r_d.rxReady = 1'b0;
				end else begin
					r_d.rxReady = isRx(r_q.tok.pid);
				end
			end
			ST_WB_COUNT: begin
				// Only receive tokens rewrite the count; pointer untouched
				if (!isRx(r_q.tok.pid)) begin
					r_d.st = ST_WB_CTRL;
				end else if (!cpuBusy) begin
					memWe = 1'b1;
					memAddr = r_q.base + `USBBDT_OFS_COUNT;
					memWd = {1'b0, r_q.cnt};
					r_d.st = ST_WB_CTRL;
				end
			end
			ST_WB_CTRL: begin
				if (!cpuBusy) begin
					memWe = 1'b1;
					memAddr = r_q.base + `USBBDT_OFS_CTRL;
					// Owner cleared, toggle kept, PID in bits 5-2
					memWd = {1'b0, r_q.ctrl[`USBBDT_BIT_TOGGLE],
						r_q.tok.pid, 2'b00};
					r_d.status = {r_q.tok.pid, r_q.tok.ep,
						r_q.tok.odd};
					r_d.doneFlag = 1'b1;
					r_d.tokDone = 1'b1;
					r_d.st = ST_IDLE;
				end
			end
		endcase
	end

	// ==========================================================
	// State register
	// ==========================================================
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r_q <= '0;
			r_q.st <= ST_IDLE;
		end else if (ce) begin
			r_q <= r_d;
		end
	end

	// ==========================================================
	// RAM write port, one writer per cycle
	// ==========================================================
	always_ff @(posedge clk) begin
		if (ce && memWe) begin
			ram[memAddr] <= memWd;
		end
	end

	// ==========================================================
	// Outputs straight from the state register
	// ==========================================================
	assign cpuRdata = r_q.rdData;
	assign descValid = r_q.descValid;
	assign descOut = r_q.desc;
	assign rxReady = r_q.rxReady;
	assign txValid = r_q.txValid;
	assign txData = r_q.txData;
	assign tokDone = r_q.tokDone;
	assign tokenDoneFlag = r_q.doneFlag;

endmodule // usbbdt_table

/* bench/usbbdt_table_assertions.sv */
`timescale 1ns/100ps
`include "usbbdt_params.svh"
// ==========================================
// Port-level checks of the descriptor table
module usbbdt_table_assertions #(
	parameter int RAM_BYTES = `USBBDT_RAM_BYTES, // Local RAM size
	parameter logic [6:0] MAX_PKT = `USBBDT_MAX_PKT // Packet ceiling
) (
	input wire logic clk, // Clock
	input wire logic resetn, // Reset, active low
	input wire logic [8:0] cpuAddr, // Processor address
	input wire logic [7:0] cpuWdata, // Processor data
	input wire logic cpuWr, // Write strobe
	input wire logic tokValid, // Token pulse
	input wire logic descValid, // Lookup pulse
	input wire usbbdt_pkg::usbbdt_desc_t descOut, // Lookup fields
	input wire logic rxReady, // Receive ready
	input wire logic xferDone, // Packet end
	input wire logic tokDone, // Write-back pulse
	input wire logic tokenDoneFlag // Sticky flag
);
	import usbbdt_pkg::*;
	logic [3:0] sinceTok; // Cycles since token
	logic [3:0] sinceXfer; // Cycles since packet end
	logic flagClr; // Firmware clears the flag
	assign flagClr = cpuWr && cpuAddr == `USBBDT_ADDR_FLAG && cpuWdata[0];
	// ==========================================
	// Age counters; saturation stops a wrap from excusing a late answer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sinceTok <= 4'hF;
			sinceXfer <= 4'hF;
		end else begin
			sinceTok <= tokValid ? 4'h0 : sinceTok + {3'h0, sinceTok != 4'hF};
			sinceXfer <= xferDone ? 4'h0 : sinceXfer + {3'h0, sinceXfer != 4'hF};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// ==========================================
	// Steps of a lookup and a write-back
	sequence s_refused;
		descValid && descOut.resp != RESP_ACK;
	endsequence
	sequence s_done_once;
		tokDone ##1 !tokDone;
	endsequence
	a_desc_pulse: assert property (descValid |=> !descValid)
		else $error("descValid longer than one cycle");
	a_done_pulse: assert property (tokDone |-> s_done_once)
		else $error("tokDone longer than one cycle");
	a_desc_latency: assert property (descValid |-> sinceTok inside {[1:10]})
		else $error("lookup answer without a recent token");
	a_done_latency: assert property (tokDone |-> sinceXfer inside {[2:10]})
		else $error("write-back without a recent packet end");
	a_reset_quiet: assert property ($rose(resetn) |-> !descValid && !tokDone)
		else $error("outputs active right after reset");
	a_flag_sets: assert property (tokDone |-> ##[0:1] tokenDoneFlag)
		else $error("token-done flag not raised");
	a_flag_holds: assert property (tokenDoneFlag && !flagClr |=> tokenDoneFlag)
		else $error("token-done flag dropped by itself");
	a_refuse_no_rx: assert property (s_refused |-> !rxReady)
		else $error("receive opened on a refused token");
endmodule // usbbdt_table_assertions

bind usbbdt_table usbbdt_table_assertions #(
	.RAM_BYTES(RAM_BYTES),
	.MAX_PKT(MAX_PKT)
) chkInst (
	.clk(clk), .resetn(resetn), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata),
	.cpuWr(cpuWr), .tokValid(tokValid), .descValid(descValid),
	.descOut(descOut), .rxReady(rxReady), .xferDone(xferDone),
	.tokDone(tokDone), .tokenDoneFlag(tokenDoneFlag)
);

/* bench/usbbdt_engine_model.sv */
`timescale 1ns/100ps
`include "usbbdt_params.svh"
// ==========================================
// Serial engine stand-in: tokens, data bytes, packet end
module usbbdt_engine_model (
	input wire logic clk, // Clock
	output logic tokValid, // Token pulse
	output usbbdt_pkg::usbbdt_token_t tokIn, // Token fields
	output logic rxValid, // Byte offered
	output logic [7:0] rxData, // Byte value
	output logic txReq, // Byte request
	output logic xferDone, // Packet end
	output logic xferToggle, // Toggle seen on the wire
	input wire logic descValid, // Lookup answer
	input wire usbbdt_pkg::usbbdt_desc_t descOut, // Answer fields
	input wire logic rxReady, // Byte sink ready
	input wire logic txValid, // Byte to send
	input wire logic [7:0] txData // Byte value
);
	import usbbdt_pkg::*;
	// Quiet lines at time zero
	initial begin
		{tokValid, rxValid, txReq, xferDone, xferToggle} = 5'h00;
		tokIn = '0;
		rxData = 8'h00;
	end
	// ==========================================
	// One token; resp 7 means no answer came
	task automatic run(input logic [2:0] e, input logic [3:0] pid,
		input logic odd, input int n, input logic tog,
		output logic [2:0] resp, output usbbdt_desc_t d, output logic [7:0] last);
		int i;
		int w;
		resp = 3'h7;
		last = 8'h00;
		d = '0;
		tokIn <= '{e, pid, odd};
		tokValid <= 1'b1;
		@(posedge clk);
		tokValid <= 1'b0;
		for (w = 0; w < 20 && resp == 3'h7; w++) begin
			@(posedge clk);
			if (descValid === 1'b1) begin
				resp = {1'b0, descOut.resp};
				d = descOut;
			end
		end
		if (resp !== 3'h0) return;
		for (i = 0; i < n; i++) begin
			w = 0;
			if (pid == `USBBDT_PID_IN) txReq <= 1'b1;
			else rxValid <= 1'b1;
			rxData <= 8'hA0 + i[7:0];
			@(posedge clk);
			txReq <= 1'b0;
			while ((pid == `USBBDT_PID_IN ? txValid : rxReady) !== 1'b1 && w < 20) begin
				@(posedge clk);
				w++;
			end
			last = txData;
		end
		// Released data line shows the inverse, never a stale byte
		rxValid <= 1'b0;
		rxData <= ~rxData;
		xferDone <= 1'b1;
		xferToggle <= tog;
		@(posedge clk);
		xferDone <= 1'b0;
	endtask
endmodule // usbbdt_engine_model

/* bench/tb_usbbdt_table.sv */
`timescale 1ns/100ps
`include "usbbdt_params.svh"
// ==========================================
// Descriptor table bench
module tb_usbbdt_table;
	import usbbdt_pkg::*;
	logic clk = 1'b0; // 40 MHz clock
	logic resetn = 1'b0; // Reset, active low
	logic [8:0] cpuAddr = 9'h000; // Processor address
	logic [7:0] cpuWdata = 8'h00; // Write data
	logic cpuWr = 1'b0; // Write strobe
	logic cpuRd = 1'b0; // Read strobe
	logic ce = 1'b1; // Clock enable, low freezes the block
	logic [7:0] cpuRdata, txData, rxData, lastTx; // Byte lanes
	logic [6:0] epEnable = 7'h7F; // Endpoint enables
	logic tokValid, descValid, rxValid, rxReady, txReq, txValid; // Engine
	logic xferDone, xferToggle, tokDone, tokenDoneFlag; // Completion
	usbbdt_token_t tokIn; // Token fields
	usbbdt_desc_t descOut; // Lookup fields
	int mismatches = 0; // Failed compares
	int n_checks = 0; // All compares
	initial begin
		forever #12.5 clk = ~clk;
	end
	// Design under test; ce is pulled low once to check the freeze
	usbbdt_table usbbdt_table_inst (.clk(clk), .resetn(resetn), .ce(ce),
		.cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuWr(cpuWr), .cpuRd(cpuRd),
		.cpuRdata(cpuRdata), .epEnable(epEnable), .tokValid(tokValid),
		.tokIn(tokIn), .descValid(descValid), .descOut(descOut),
		.rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .txReq(txReq),
		.txValid(txValid), .txData(txData), .xferDone(xferDone),
		.xferToggle(xferToggle), .tokDone(tokDone),
		.tokenDoneFlag(tokenDoneFlag));
	usbbdt_engine_model usbbdt_engine_model_inst (.clk(clk),
		.tokValid(tokValid), .tokIn(tokIn), .rxValid(rxValid),
		.rxData(rxData), .txReq(txReq), .xferDone(xferDone),
		.xferToggle(xferToggle), .descValid(descValid), .descOut(descOut),
		.rxReady(rxReady), .txValid(txValid), .txData(txData));
	// ==========================================
	// Bus tasks; a gap cycle keeps strobes from being set twice at one edge
	task automatic wr(input logic [8:0] a, input logic [7:0] v);
		cpuWr <= 1'b1;
		cpuAddr <= a;
		cpuWdata <= v;
		@(posedge clk);
		cpuWr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [8:0] a, output logic [7:0] v);
		cpuRd <= 1'b1;
		cpuAddr <= a;
		@(posedge clk);
		cpuRd <= 1'b0;
		@(posedge clk);
		v = cpuRdata;
	endtask
	task automatic chk(input string nm, input logic [7:0] s, e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic rdchk(input logic [8:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk($sformatf("ram %h", a), v, e);
	endtask
	// Watch for the write-back pulse over a bounded span
	task automatic wait_done(input logic e);
		logic got;
		got = 1'b0;
		repeat (12) begin
			@(posedge clk);
			if (tokDone === 1'b1) got = 1'b1;
		end
		chk("tokDone", {7'h0, got}, {7'h0, e});
	endtask
	// Prepare a descriptor, run a token, check what was written back
	task automatic xfer(input logic [8:0] b, input logic [7:0] c, cn, p,
		input logic [2:0] e, input logic [3:0] pid, input int n,
		input logic tog, dn, input logic [7:0] ec, en);
		logic [2:0] r;
		usbbdt_desc_t d;
		wr(b + 9'h1, cn);
		wr(b + 9'h2, p);
		// Control byte last, then hands off until the write-back
		wr(b, c);
		usbbdt_engine_model_inst.run(e, pid, 1'b0, n, tog, r, d, lastTx);
		chk("ack", {5'h0, r}, 8'h00);
		chk("toggle", {7'h0, d.toggle}, {7'h0, c[6]});
		chk("sync", {7'h0, d.sync}, {7'h0, c[3]});
		chk("count", d.count, cn);
		wait_done(dn);
		rdchk(b, ec);
		rdchk(b + 9'h1, en);
		rdchk(b + 9'h2, p);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Watchdog well past the expected run of under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		stop_test();
	end
	// ==========================================
	// Main sequence
	initial begin
		logic [2:0] r;
		logic [2:0] e;
		usbbdt_desc_t d;
		int i;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rdchk(`USBBDT_ADDR_FLAG, 8'h00);
		rdchk(9'h1FF, 8'h00);
		for (i = 0; i < 30; i++) wr(9'(i), 8'h00);
		wr(9'h0FF, 8'hC3);
		rdchk(9'h0FF, 8'hC3);
		// A write while frozen must not land
		ce <= 1'b0;
		wr(9'h0FF, 8'h3C);
		ce <= 1'b1;
		rdchk(9'h0FF, 8'hC3);
		// Stall one slot at a time; a wrong slot would answer NAK
		for (i = 0; i < 10; i++) begin
			e = 3'(i < 2 ? 0 : (i < 6 ? i - 1 : (i < 8 ? 5 : 6)));
			wr(9'(i * 3), 8'h84);
			usbbdt_engine_model_inst.run(e, i == 0 ? `USBBDT_PID_IN :
				`USBBDT_PID_OUT, i > 5 && i[0], 1, 1'b0, r, d, lastTx);
			chk("stall", {5'h0, r}, 8'h02);
			rdchk(9'(i * 3), 8'h84);
			wr(9'(i * 3), 8'h00);
		end
		// A processor read in the lookup slot delays the engine only
		wr(9'h015, 8'h84);
		fork
			usbbdt_engine_model_inst.run(3'h5, `USBBDT_PID_OUT, 1'b1, 1, 1'b0, r,
				d, lastTx);
			begin
				@(posedge clk);
				rdchk(9'h0FF, 8'hC3);
			end
		join
		chk("stall busy", {5'h0, r}, 8'h02);
		wr(9'h015, 8'h00);
		xfer(9'h006, 8'hC0, 8'h40, 8'h10, 3'h1, `USBBDT_PID_OUT, 3, 1, 1,
			8'h44, 8'h03);
		rdchk(9'h042, 8'hA2);
		rdchk(`USBBDT_ADDR_STATUS, 8'h12);
		rdchk(`USBBDT_ADDR_FLAG, 8'h01);
		chk("flag pin", {7'h0, tokenDoneFlag}, 8'h01);
		wr(`USBBDT_ADDR_FLAG, 8'h01);
		rdchk(`USBBDT_ADDR_FLAG, 8'h00);
		chk("flag pin", {7'h0, tokenDoneFlag}, 8'h00);
		usbbdt_engine_model_inst.run(3'h1, `USBBDT_PID_OUT, 1'b0, 1, 1'b0, r, d,
			lastTx);
		chk("nak", {5'h0, r}, 8'h01);
		xfer(9'h003, 8'h80, 8'h40, 8'h14, 3'h0, `USBBDT_PID_SETUP, 8, 0, 1,
			8'h34, 8'h08);
		rdchk(9'h057, 8'hA7);
		wr(9'h030, 8'h11);
		wr(9'h031, 8'h22);
		xfer(9'h000, 8'h80, 8'h02, 8'h0C, 3'h0, `USBBDT_PID_IN, 2, 0, 1,
			8'h24, 8'h02);
		chk("tx byte", lastTx, 8'h22);
		wr(9'h0C0, 8'h5A);
		xfer(9'h009, 8'h80, 8'h40, 8'h20, 3'h2, `USBBDT_PID_OUT, 66, 0, 1,
			8'h04, 8'h40);
		rdchk(9'h0BF, 8'hDF);
		rdchk(9'h0C0, 8'h5A);
		xfer(9'h00C, 8'h88, 8'h40, 8'h28, 3'h3, `USBBDT_PID_OUT, 1, 1, 0,
			8'h88, 8'h40);
		xfer(9'h00F, 8'hC8, 8'h40, 8'h2C, 3'h4, `USBBDT_PID_OUT, 1, 1, 1,
			8'h44, 8'h01);
		epEnable <= 7'h7D;
		usbbdt_engine_model_inst.run(3'h1, `USBBDT_PID_OUT, 1'b0, 1, 1'b0, r, d,
			lastTx);
		chk("disabled", {5'h0, r}, 8'h07);
		stop_test();
	end
endmodule // tb_usbbdt_table
